// file: mie_pkg.sv
package mie_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 10;
  localparam int RAM_N = 64;
  localparam logic [9:0] PC_ONE = 10'h001;
  localparam logic [9:0] PC_TWO = 10'h002;
  localparam logic [9:0] PC_RST = 10'h000;
  localparam logic [9:0] IRQ_VECTOR = 10'h004;
  localparam logic [1:0] LAST_PAGE = 2'h3;

  // ----------------------------------------------------------------
  // special data memory locations
  // ----------------------------------------------------------------
  localparam logic [6:0] SFR_PCLO = 7'h02;
  localparam logic [6:0] SFR_TPTR = 7'h03;
  localparam logic [6:0] SFR_THI = 7'h04;
  localparam logic [6:0] SFR_FLAGS = 7'h05;
  localparam logic [6:0] RAM_BASE = 7'h10;

  // ----------------------------------------------------------------
  // watchdog timing (prescaler counts system clocks, counter counts prescaler wraps)
  // ----------------------------------------------------------------
  localparam logic [3:0] WD_PRE_MAX = 4'hF;
  localparam logic [7:0] WD_CNT_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // register map seen over the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_WREG = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int STAT_HALT_BIT = 8;
  localparam logic CTRL_RUN_RST = 1'b0;

  // ----------------------------------------------------------------
  // opcodes, instruction word [15:10]
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'h00, OP_LOAD_M = 6'h01, OP_STORE_M = 6'h02,
    OP_LOAD_X = 6'h03, OP_BIT_CLR = 6'h04, OP_BIT_SET = 6'h05,
    OP_BRANCH = 6'h06, OP_SKIP_NULL = 6'h07, OP_SKIP_NULL_A = 6'h08,
    OP_SKIP_BIT0 = 6'h09, OP_SKIP_BIT1 = 6'h0A, OP_BUMP_UP = 6'h0B,
    OP_BUMP_DN = 6'h0C, OP_BUMP_UP_A = 6'h0D, OP_BUMP_DN_A = 6'h0E,
    OP_INVOKE = 6'h0F, OP_SUB_EXIT = 6'h10, OP_SUB_EXIT_X = 6'h11,
    OP_IRQ_EXIT = 6'h12, OP_LOOKUP = 6'h13, OP_LOOKUP_LAST = 6'h14,
    OP_ZERO_M = 6'h15, OP_ONES_M = 6'h16, OP_KICK = 6'h17,
    OP_NIBX = 6'h18, OP_NIBX_A = 6'h19, OP_SLEEP = 6'h1A,
    OP_ADDC = 6'h1B, OP_ADDC_M = 6'h1C, OP_ADDW = 6'h1D,
    OP_ADDW_X = 6'h1E, OP_ADDW_M = 6'h1F, OP_ANDW = 6'h20,
    OP_ANDW_X = 6'h21, OP_ANDW_M = 6'h22, OP_INVERT = 6'h23,
    OP_INVERT_A = 6'h24, OP_BCD_FIX = 6'h25
  } mie_op_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0, ST_DUMMY = 2'h1, ST_TABLE = 2'h2, ST_HALT = 2'h3
  } mie_state_t;

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mie_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } mie_apb_rsp_t;
endpackage : mie_pkg

// file: mie_core.sv
`timescale 1ns/1ps
// Function
// RL1 - moves memory/working register/immediate take one cycle, no flags
// RL2 - invoke and branch take two cycles, no flags changed
// RL3 - skip costs two cycles when taken, one otherwise
// RL4 - writing program counter low byte costs two cycles
// RL5 - rom lookup: high part to table byte, low to memory, 2 cycles
// RL6 - skip on zero byte (optional copy), on bit zero, on bit one
// RL7 - bump up/down and skip on zero; register forms keep memory
// RL8 - the three returns take two cycles, no arithmetic flag
// RL9 - watchdog kick clears counter, timeout and power-down flags
// RL10 - nibble exchange to memory or working register, one cycle
// RL11 - add with carry updates four arithmetic flags
// RL12 - plain add of memory or immediate updates four flags
// RL13 - AND with memory or immediate updates only zero
// RL14 - invoke pushes pc plus one and jumps to target
// RL15 - clear byte writes zero, set byte writes all ones
// RL16 - bit clear/set touches only the selected bit
// RL17 - invert-all complements memory byte, updates zero only
// RL18 - invert-to-register leaves memory, updates zero, one cycle
// RL19 - bcd fixup adds 6 to low nibble above 9 or half carry
// RL20 - bcd fixup adds 6 to high nibble above 9 or carry; code tests the whole byte above 99 instead
// RL21 - bcd fixup changes only carry, set when sum passes 100
// RL22 - power-down executes in one cycle and updates its flags
// RL23 - power-down stops execution, clears watchdog, sets flag
// RL24 - interrupt exit restores pc, opens gate, pending irq first
// RL25 - branch loads target with a dummy slot
// RL26 - a taken skip discards the fetched instruction
// RL27 - no-operation changes nothing and moves to next word
module mie_core (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // register bus
  input wire mie_pkg::mie_apb_req_t APB_REQ,
  output mie_pkg::mie_apb_rsp_t APB_RSP,
  // program memory
  output logic [9:0] PROG_ADDR,
  input wire logic [15:0] PROG_DATA,
  // interrupt request pin
  input wire logic IRQ
);

  typedef struct packed {
    mie_pkg::mie_state_t st;
    logic [9:0] pc;
    logic [9:0] prog_addr;
    logic [7:0] wreg;
    logic c, hc, z, sr, wto, powerdown_flag, gate, run;
    logic irq_s1, irq_s2;
    logic [1:0] sp;
    logic [3:0][9:0] stk;
    logic [63:0][7:0] ram;
    logic [7:0] tptr, thi;
    logic [6:0] tdst;
    logic [7:0] wdog;
    logic [3:0] pre;
    mie_pkg::mie_apb_rsp_t rsp;
  } mie_state_all_t;

  mie_state_all_t s, n;
  mie_pkg::mie_op_t op;
  logic [6:0] ma;
  logic [2:0] bi;
  logic [7:0] imm, md, wd, res, adj;
  logic [10:0] sum;
  logic wr, go, bus_wr, lo_fix, hi_fix;
  logic [6:0] wa;
  logic [32:0] rdv;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // data memory read, special locations first
  function automatic logic [7:0] rd_mem(mie_state_all_t v,
                                        logic [6:0] a);
    logic [6:0] i;
    i = a - mie_pkg::RAM_BASE;
    if (a == mie_pkg::SFR_PCLO) return v.pc[7:0];
    if (a == mie_pkg::SFR_TPTR) return v.tptr;
    if (a == mie_pkg::SFR_THI) return v.thi;
    if (a == mie_pkg::SFR_FLAGS)
      return {2'h0, v.wto, v.powerdown_flag, v.sr, v.z, v.hc, v.c};
    if (a >= mie_pkg::RAM_BASE && i < 7'(mie_pkg::RAM_N))
      return v.ram[i[5:0]];
    return 8'h00;
  endfunction : rd_mem

  // 8-bit add giving {signed range, half carry, carry, sum}
  function automatic logic [10:0] add8(logic [7:0] a, logic [7:0] b,
                                       logic ci);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {(a[7] == b[7]) && (t[7] != a[7]), h[4], t[8], t[7:0]};
  endfunction : add8

  // bus read decode: {error, data}
  function automatic logic [32:0] rd_reg(mie_state_all_t v,
                                         logic [7:0] a);
    case (a)
      mie_pkg::REG_CTRL: return {1'b0, 31'h0, v.run};
      mie_pkg::REG_STAT: return {1'b0, 23'h0, v.st == mie_pkg::ST_HALT,
                                 2'h0, v.wto, v.powerdown_flag, v.sr, v.z, v.hc, v.c};
      mie_pkg::REG_PC: return {1'b0, 22'h0, v.pc};
      mie_pkg::REG_WREG: return {1'b0, 24'h0, v.wreg};
      default: return {1'b1, 32'h0};
    endcase
  endfunction : rd_reg

  assign op = mie_pkg::mie_op_t'(PROG_DATA[15:10]);
  assign ma = PROG_DATA[6:0];
  assign bi = PROG_DATA[9:7];
  assign imm = PROG_DATA[7:0];
  assign go = CE && s.run && s.st == mie_pkg::ST_EXEC;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    md = rd_mem(s, ma);
    wr = 1'b0;
    wa = ma;
    wd = 8'h00;
    res = 8'h00;
    sum = 11'h000;
    lo_fix = (s.wreg[3:0] > 4'h9) || s.hc;
    hi_fix = (s.wreg > 8'h99) || s.c; // see RL20
    adj = {hi_fix ? 4'h6 : 4'h0, lo_fix ? 4'h6 : 4'h0};
    // irq pin through two flops before use
    n.irq_s1 = IRQ;
    n.irq_s2 = s.irq_s1;
    // watchdog runs only while the system clock would run
    if (s.st != mie_pkg::ST_HALT) begin
      n.pre = s.pre + 4'h1;
      if (s.pre == mie_pkg::WD_PRE_MAX) begin
        n.wdog = s.wdog + 8'h01;
        if (s.wdog == mie_pkg::WD_CNT_MAX) n.wto = 1'b1;
      end
    end
    // bus slave: zero wait, data captured in the setup cycle
    bus_wr = APB_REQ.psel && APB_REQ.penable && s.rsp.pready &&
             APB_REQ.pwrite;
    rdv = rd_reg(s, APB_REQ.paddr);
    n.rsp.pready = APB_REQ.psel && !APB_REQ.penable;
    if (APB_REQ.psel && !APB_REQ.penable) begin
      n.rsp.prdata = APB_REQ.pwrite ? 32'h0 : rdv[31:0];
      n.rsp.pslverr = rdv[32];
    end
    if (bus_wr && APB_REQ.paddr == mie_pkg::REG_CTRL) begin
      n.run = APB_REQ.pwdata[mie_pkg::CTRL_RUN_BIT];
    end
    case (s.st)
      mie_pkg::ST_EXEC: begin
        if (s.run) begin
          n.pc = s.pc + mie_pkg::PC_ONE;
          if (s.gate && s.irq_s2) begin
            // fetched word is dropped and re-fetched after the service
            n.stk[s.sp] = s.pc;
            n.sp = s.sp + 2'h1;
            n.pc = mie_pkg::IRQ_VECTOR;
            n.gate = 1'b0;
            n.st = mie_pkg::ST_DUMMY;
          end else begin
            case (op)
              mie_pkg::OP_LOAD_M: n.wreg = md; // see RL1
              mie_pkg::OP_STORE_M: begin
                wr = 1'b1; // see RL1
                wd = s.wreg;
              end
              mie_pkg::OP_LOAD_X: n.wreg = imm; // see RL1
              mie_pkg::OP_BIT_CLR, mie_pkg::OP_BIT_SET: begin
                wr = 1'b1;
                wd = md;
                wd[bi] = (op == mie_pkg::OP_BIT_SET); // see RL16
              end
              mie_pkg::OP_BRANCH: begin
                n.pc = PROG_DATA[9:0]; // see RL25
                n.st = mie_pkg::ST_DUMMY; // see RL2
              end
              mie_pkg::OP_INVOKE: begin
                n.stk[s.sp] = s.pc + mie_pkg::PC_ONE; // see RL14
                n.sp = s.sp + 2'h1;
                n.pc = PROG_DATA[9:0];
                n.st = mie_pkg::ST_DUMMY; // see RL2
              end
              mie_pkg::OP_SKIP_NULL, mie_pkg::OP_SKIP_NULL_A: begin
                if (op == mie_pkg::OP_SKIP_NULL_A) n.wreg = md;
                if (md == 8'h00) begin // see RL6
                  n.pc = s.pc + mie_pkg::PC_TWO; // see RL26
                  n.st = mie_pkg::ST_DUMMY; // see RL3
                end
              end
              mie_pkg::OP_SKIP_BIT0, mie_pkg::OP_SKIP_BIT1: begin
                if (md[bi] == (op == mie_pkg::OP_SKIP_BIT1)) begin
                  n.pc = s.pc + mie_pkg::PC_TWO; // see RL6
                  n.st = mie_pkg::ST_DUMMY; // see RL3
                end
              end
              mie_pkg::OP_BUMP_UP, mie_pkg::OP_BUMP_DN,
              mie_pkg::OP_BUMP_UP_A, mie_pkg::OP_BUMP_DN_A: begin
                res = (op == mie_pkg::OP_BUMP_UP ||
                       op == mie_pkg::OP_BUMP_UP_A) ? md + 8'h01
                                                    : md - 8'h01;
                if (op == mie_pkg::OP_BUMP_UP ||
                    op == mie_pkg::OP_BUMP_DN) begin
                  wr = 1'b1;
                  wd = res;
                end else begin
                  n.wreg = res; // see RL7
                end
                if (res == 8'h00) begin
                  n.pc = s.pc + mie_pkg::PC_TWO; // see RL7
                  n.st = mie_pkg::ST_DUMMY; // see RL3
                end
              end
              mie_pkg::OP_SUB_EXIT, mie_pkg::OP_SUB_EXIT_X,
              mie_pkg::OP_IRQ_EXIT: begin
                n.sp = s.sp - 2'h1;
                n.pc = s.stk[s.sp - 2'h1]; // see RL8
                n.st = mie_pkg::ST_DUMMY;
                if (op == mie_pkg::OP_SUB_EXIT_X) n.wreg = imm;
                // gate opens now; a pending irq is taken before the
                // first word at the restored address executes
                if (op == mie_pkg::OP_IRQ_EXIT) n.gate = 1'b1; // see RL24
              end
              mie_pkg::OP_LOOKUP, mie_pkg::OP_LOOKUP_LAST: begin
                n.tdst = ma;
                n.prog_addr = {op == mie_pkg::OP_LOOKUP_LAST ?
                               mie_pkg::LAST_PAGE : s.pc[9:8], s.tptr};
                n.st = mie_pkg::ST_TABLE; // see RL5
              end
              mie_pkg::OP_ZERO_M, mie_pkg::OP_ONES_M: begin
                wr = 1'b1;
                wd = (op == mie_pkg::OP_ONES_M) ? 8'hFF : 8'h00; // see RL15
              end
              mie_pkg::OP_KICK: begin
                n.wdog = 8'h00; // see RL9
                n.pre = 4'h0;
                n.wto = 1'b0;
                n.powerdown_flag = 1'b0;
              end
              mie_pkg::OP_NIBX: begin
                wr = 1'b1;
                wd = {md[3:0], md[7:4]}; // see RL10
              end
              mie_pkg::OP_NIBX_A: n.wreg = {md[3:0], md[7:4]}; // see RL10
              mie_pkg::OP_SLEEP: begin
                n.wdog = 8'h00; // see RL23
                n.pre = 4'h0;
                n.wto = 1'b0; // see RL22
                n.powerdown_flag = 1'b1;
                n.st = mie_pkg::ST_HALT;
              end
              mie_pkg::OP_ADDC, mie_pkg::OP_ADDC_M, mie_pkg::OP_ADDW,
              mie_pkg::OP_ADDW_X, mie_pkg::OP_ADDW_M: begin
                sum = add8(s.wreg, op == mie_pkg::OP_ADDW_X ? imm : md,
                           (op == mie_pkg::OP_ADDC ||
                            op == mie_pkg::OP_ADDC_M) && s.c); // see RL11
                {n.sr, n.hc, n.c} = sum[10:8]; // see RL12
                n.z = (sum[7:0] == 8'h00);
                if (op == mie_pkg::OP_ADDC_M || op == mie_pkg::OP_ADDW_M)
                begin
                  wr = 1'b1;
                  wd = sum[7:0];
                end else begin
                  n.wreg = sum[7:0];
                end
              end
              mie_pkg::OP_ANDW, mie_pkg::OP_ANDW_X, mie_pkg::OP_ANDW_M:
              begin
                res = s.wreg & (op == mie_pkg::OP_ANDW_X ? imm : md);
                n.z = (res == 8'h00); // see RL13
                if (op == mie_pkg::OP_ANDW_M) begin
                  wr = 1'b1;
                  wd = res;
                end else begin
                  n.wreg = res;
                end
              end
              mie_pkg::OP_INVERT: begin
                wr = 1'b1;
                wd = ~md; // see RL17
                n.z = (wd == 8'h00);
              end
              mie_pkg::OP_INVERT_A: begin
                n.wreg = ~md; // see RL18
                n.z = (md == 8'hFF);
              end
              mie_pkg::OP_BCD_FIX: begin
                wr = 1'b1;
                wd = s.wreg + adj; // see RL19
                n.c = hi_fix; // see RL21
              end
              default: ; // unknown words act as no-operation; see RL27
            endcase
          end
        end
      end
      mie_pkg::ST_TABLE: begin
        n.thi = PROG_DATA[15:8]; // see RL5
        wr = 1'b1;
        wa = s.tdst;
        wd = PROG_DATA[7:0];
        n.st = mie_pkg::ST_EXEC;
      end
      mie_pkg::ST_HALT: begin
        if (bus_wr && APB_REQ.paddr == mie_pkg::REG_CTRL &&
            APB_REQ.pwdata[mie_pkg::CTRL_WAKE_BIT]) begin
          n.st = mie_pkg::ST_EXEC;
        end
      end
      default: n.st = mie_pkg::ST_EXEC; // dummy slot ends here
    endcase
    // single data memory write port; a write to pc low byte reloads
    // the fetch address and so always spends a dummy slot
    if (wr) begin
      if (wa == mie_pkg::SFR_PCLO) begin
        n.pc = {s.pc[9:8], wd}; // see RL4
        n.st = mie_pkg::ST_DUMMY;
      end else if (wa == mie_pkg::SFR_TPTR) begin
        n.tptr = wd;
      end else if (wa == mie_pkg::SFR_THI) begin
        n.thi = wd;
      end else if (wa == mie_pkg::SFR_FLAGS) begin
        {n.sr, n.z, n.hc, n.c} = wd[3:0];
      end else if (wa >= mie_pkg::RAM_BASE &&
                   (wa - mie_pkg::RAM_BASE) < 7'(mie_pkg::RAM_N)) begin
        n.ram[6'(wa - mie_pkg::RAM_BASE)] = wd;
      end
    end
    if (n.st != mie_pkg::ST_TABLE) n.prog_addr = n.pc;
  end

  // ----------------------------------------------------------------
  // state register; low enable freezes everything
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      s <= '0;
      s.st <= mie_pkg::ST_EXEC;
      s.pc <= mie_pkg::PC_RST;
      s.prog_addr <= mie_pkg::PC_RST;
      s.run <= mie_pkg::CTRL_RUN_RST;
    end else if (CE) begin
      s <= n;
    end
  end

  assign APB_RSP = s.rsp;
  assign PROG_ADDR = s.prog_addr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  logic take_irq;
  assign take_irq = s.gate && s.irq_s2;

  sequence dummy_then_exec;
    (s.st == mie_pkg::ST_DUMMY) ##1 (s.st == mie_pkg::ST_EXEC);
  endsequence

  a_move_keeps_flags: assert property ( // see RL1
    go && !take_irq && op == mie_pkg::OP_LOAD_M |=>
    s.wreg == $past(md) && {s.c, s.hc, s.z, s.sr} ==
    $past({s.c, s.hc, s.z, s.sr}))
    else $error("move changed flags or missed data");
  a_branch_dummy_slot: assert property ( // see RL2
    go && !take_irq && op == mie_pkg::OP_BRANCH ##1 CE |->
    dummy_then_exec and (s.pc == $past(PROG_DATA[9:0])))
    else $error("branch did not take two cycles");
  a_skip_two_cycles: assert property ( // see RL3
    go && !take_irq && op == mie_pkg::OP_SKIP_NULL && md == 8'h00 |=>
    s.st == mie_pkg::ST_DUMMY && s.pc == $past(s.pc) + mie_pkg::PC_TWO)
    else $error("taken skip did not insert dummy slot");
  a_noskip_one_cycle: assert property ( // see RL3
    go && !take_irq && op == mie_pkg::OP_SKIP_NULL && md != 8'h00 |=>
    s.st == mie_pkg::ST_EXEC)
    else $error("untaken skip spent extra cycle");
  a_invoke_push_pc: assert property ( // see RL14
    go && !take_irq && op == mie_pkg::OP_INVOKE |=>
    s.stk[$past(s.sp)] == $past(s.pc) + mie_pkg::PC_ONE &&
    s.sp == $past(s.sp) + 2'h1)
    else $error("invoke pushed wrong return address");
  a_kick_clears_dog: assert property ( // see RL9
    go && !take_irq && op == mie_pkg::OP_KICK |=>
    s.wdog == 8'h00 && !s.wto && !s.powerdown_flag)
    else $error("kick left watchdog state set");
  a_sleep_sets_flags: assert property ( // see RL22
    go && !take_irq && op == mie_pkg::OP_SLEEP |=>
    s.powerdown_flag && !s.wto && s.st == mie_pkg::ST_HALT)
    else $error("power-down flags wrong");
  a_irq_exit_gate: assert property ( // see RL24
    go && !take_irq && op == mie_pkg::OP_IRQ_EXIT |=>
    s.gate && s.pc == $past(s.stk[s.sp - 2'h1]))
    else $error("interrupt exit did not restore");
  a_bcd_carry_out: assert property ( // see RL21
    go && !take_irq && op == mie_pkg::OP_BCD_FIX && s.wreg > 8'h99 |=>
    s.c && s.z == $past(s.z) && s.hc == $past(s.hc))
    else $error("bcd fixup carry wrong");

endmodule : mie_core

// file: mie_rom_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// program memory seen by the core
// ----------------------------------------------------------------
module mie_rom_model (
  // fetch port
  input wire logic [9:0] addr,
  output logic [15:0] data
);
  logic [15:0] mem [1024];

  // asynchronous read; the core samples the word in the same cycle
  assign data = mem[addr];
endmodule : mie_rom_model

// file: mie_core_tb_top.sv
`timescale 1ns/1ps
module mie_core_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic irq = 1'b0;
  mie_pkg::mie_apb_req_t req = '0;
  mie_pkg::mie_apb_rsp_t rsp;
  logic [9:0] prog_addr;
  logic [15:0] prog_data;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // design, program memory, clock and watchdog of the run
  // ----------------------------------------------------------------
  mie_core DUT (.CLOCK(clock), .RST(rst), .CE(ce), .APB_REQ(req),
    .APB_RSP(rsp), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
    .IRQ(irq));
  mie_rom_model ROM (.addr(prog_addr), .data(prog_data));

  initial forever #2.5 clock = ~clock;

  // a hang anywhere ends the run as a failure
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // bus master: setup, then access held until pready is sampled
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (n >= 50) chk(32'h0, 32'h1, "pready never came");
    req <= '0;
  endtask : apb

  task automatic put(input logic [9:0] a, input mie_pkg::mie_op_t op,
                     input logic [9:0] low);
    ROM.mem[a] = {op, low};
  endtask : put

  // unused opcode everywhere; the core runs a stray fetch of it as a nop
  task automatic clear_rom();
    for (int k = 0; k < 1024; k++) ROM.mem[k] = 16'hFFFF;
  endtask : clear_rom

  // reset, start, time the path from word 1 to word last, then read back
  task automatic run(input logic [9:0] last, input int exp_cyc,
                     input logic [7:0] exp_w, input logic [31:0] st_mask,
                     input logic [31:0] exp_st);
    logic [31:0] rd;
    logic err;
    int t0;
    int t1;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    apb(1'b1, mie_pkg::REG_CTRL, 32'h1, rd, err);
    t0 = -1;
    t1 = -1;
    for (int k = 0; k < 500 && t1 < 0; k++) begin
      @(posedge clock);
      if (t0 < 0 && prog_addr === 10'h001) t0 = k;
      if (t0 >= 0 && prog_addr === last) t1 = k;
    end
    chk(t1 - t0, exp_cyc, "cycle count");
    for (int k = 0; k < 20; k++) begin
      apb(1'b0, mie_pkg::REG_STAT, 32'h0, rd, err);
      if (rd[mie_pkg::STAT_HALT_BIT] === 1'b1) break;
    end
    chk(rd & st_mask, exp_st, "status");
    apb(1'b0, mie_pkg::REG_WREG, 32'h0, rd, err);
    chk(rd, {24'h0, exp_w}, "working register");
  endtask : run

  // expected {flags, result}; flags are [0]C [1]half [2]Z [3]signed
  function automatic logic [11:0] expect_res(mie_pkg::mie_op_t op,
    logic [7:0] a, logic [7:0] b, logic [3:0] f, logic [2:0] n);
    logic [8:0] s;
    logic [4:0] h;
    logic [3:0] fl;
    logic [7:0] r;
    logic ci;
    logic lo;
    logic hi;
    fl = f;
    r = b;
    ci = (op inside {mie_pkg::OP_ADDC, mie_pkg::OP_ADDC_M}) ? f[0] : 1'b0;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    case (op)
      mie_pkg::OP_ADDW_M, mie_pkg::OP_ADDC, mie_pkg::OP_ADDW_X,
      mie_pkg::OP_ADDW, mie_pkg::OP_ADDC_M: begin
        r = s[7:0];
        fl[0] = s[8];
        fl[1] = h[4];
        fl[3] = (a[7] == b[7]) && (s[7] != a[7]);
      end
      mie_pkg::OP_ANDW_M, mie_pkg::OP_ANDW_X, mie_pkg::OP_ANDW: r = a & b;
      mie_pkg::OP_BCD_FIX: begin
        lo = (b[3:0] > 4'h9) || f[1];
        hi = (b > 8'h99) || f[0];
        r = b + {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
        fl[0] = hi;
      end
      mie_pkg::OP_INVERT, mie_pkg::OP_INVERT_A: r = ~a;
      mie_pkg::OP_NIBX, mie_pkg::OP_NIBX_A: r = {a[3:0], a[7:4]};
      mie_pkg::OP_ZERO_M: r = 8'h00;
      mie_pkg::OP_ONES_M: r = 8'hFF;
      mie_pkg::OP_BIT_SET: r = a | (8'h01 << n);
      mie_pkg::OP_BIT_CLR: r = a & ~(8'h01 << n);
      default: r = b;
    endcase
    if (op inside {mie_pkg::OP_ADDW_M, mie_pkg::OP_ADDC, mie_pkg::OP_ADDW_X,
        mie_pkg::OP_ANDW_M, mie_pkg::OP_ANDW_X, mie_pkg::OP_INVERT,
        mie_pkg::OP_INVERT_A, mie_pkg::OP_ADDW, mie_pkg::OP_ADDC_M,
        mie_pkg::OP_ANDW}) fl[2] = (r == 8'h00);
    return {fl, r};
  endfunction : expect_res

  // flags preset through memory, operands a (memory) and b (register)
  task automatic arith(input mie_pkg::mie_op_t op, input logic [7:0] a,
    input logic [7:0] b, input logic [3:0] f, input logic [2:0] n,
    input logic [6:0] m);
    logic [11:0] e;
    logic reg_form;
    reg_form = op inside {mie_pkg::OP_ADDC, mie_pkg::OP_ADDW_X,
      mie_pkg::OP_ANDW_X, mie_pkg::OP_INVERT_A, mie_pkg::OP_NIBX_A,
      mie_pkg::OP_ADDW, mie_pkg::OP_ANDW};
    clear_rom();
    put(10'h0, mie_pkg::OP_KICK, 10'h0);
    put(10'h1, mie_pkg::OP_LOAD_X, {6'h0, f});
    put(10'h2, mie_pkg::OP_STORE_M, {3'h0, mie_pkg::SFR_FLAGS});
    put(10'h3, mie_pkg::OP_LOAD_X, {2'h0, a});
    put(10'h4, mie_pkg::OP_STORE_M, {3'h0, m});
    put(10'h5, mie_pkg::OP_LOAD_X, {2'h0, b});
    if (op == mie_pkg::OP_ADDW_X || op == mie_pkg::OP_ANDW_X)
      put(10'h6, op, {2'h0, a});
    else put(10'h6, op, {n, m});
    put(10'h7, reg_form ? mie_pkg::OP_NOP : mie_pkg::OP_LOAD_M, {3'h0, m});
    put(10'h8, mie_pkg::OP_SLEEP, 10'h0);
    e = expect_res(op, a, b, f, n);
    run(10'h8, 7, e[7:0], 32'h13F, {23'h0, 9'h110} | {28'h0, e[11:8]});
  endtask : arith

  initial begin
    logic [31:0] rd;
    logic err;
    logic [7:0] a;
    logic [7:0] b;
    mie_pkg::mie_op_t ops [$];
    ops = '{mie_pkg::OP_ADDW_M, mie_pkg::OP_ADDC, mie_pkg::OP_ADDW_X,
      mie_pkg::OP_ANDW_M, mie_pkg::OP_ANDW_X, mie_pkg::OP_BCD_FIX,
      mie_pkg::OP_INVERT, mie_pkg::OP_INVERT_A, mie_pkg::OP_NIBX,
      mie_pkg::OP_NIBX_A, mie_pkg::OP_ZERO_M, mie_pkg::OP_ONES_M,
      mie_pkg::OP_BIT_SET, mie_pkg::OP_BIT_CLR, mie_pkg::OP_ADDW,
      mie_pkg::OP_ADDC_M, mie_pkg::OP_ANDW};
    void'($urandom(80292));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // unmapped address is refused, run bit comes up clear
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk(rd, 32'h0, "unmapped read data");
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b0, mie_pkg::REG_CTRL, 32'h0, rd, err);
    chk(rd, 32'h0, "control after reset");
    // skips taken and not, branch, pc low write, invoke and return
    clear_rom();
    put(10'h0, mie_pkg::OP_NOP, 10'h0);
    put(10'h1, mie_pkg::OP_LOAD_X, 10'h0);
    put(10'h2, mie_pkg::OP_STORE_M, {3'h0, mie_pkg::RAM_BASE});
    put(10'h3, mie_pkg::OP_SKIP_NULL, {3'h0, mie_pkg::RAM_BASE});
    put(10'h4, mie_pkg::OP_LOAD_X, 10'h0EE);
    put(10'h5, mie_pkg::OP_BUMP_UP, {3'h0, mie_pkg::RAM_BASE});
    put(10'h6, mie_pkg::OP_SKIP_BIT1, {3'h0, mie_pkg::RAM_BASE});
    put(10'h7, mie_pkg::OP_LOAD_X, 10'h0EE);
    put(10'h8, mie_pkg::OP_BRANCH, 10'h00A);
    put(10'h9, mie_pkg::OP_LOAD_X, 10'h0EE);
    put(10'hA, mie_pkg::OP_LOAD_X, 10'h00D);
    put(10'hB, mie_pkg::OP_STORE_M, {3'h0, mie_pkg::SFR_PCLO});
    put(10'hC, mie_pkg::OP_LOAD_X, 10'h0EE);
    put(10'hD, mie_pkg::OP_INVOKE, 10'h020);
    put(10'hE, mie_pkg::OP_INVOKE, 10'h022);
    put(10'hF, mie_pkg::OP_SLEEP, 10'h0);
    put(10'h20, mie_pkg::OP_SKIP_NULL, {3'h0, mie_pkg::RAM_BASE});
    put(10'h21, mie_pkg::OP_SUB_EXIT_X, 10'h05A);
    put(10'h22, mie_pkg::OP_IRQ_EXIT, 10'h0);
    // word F runs at 21; the return's dummy slot shows it one cycle early
    run(10'hF, 20, 8'h5A, 32'h130, 32'h110);
    // every arithmetic, logic and byte operation except bump up/down, corner case first
    for (int i = 0; i < ops.size(); i++) begin
      for (int j = 0; j < 3; j++) begin
        a = (j == 0) ? 8'h80 : 8'($urandom);
        b = (j == 0) ? 8'h80 : 8'($urandom);
        arith(ops[i], a, b, 4'($urandom), 3'($urandom),
          mie_pkg::RAM_BASE + 7'($urandom % 64));
      end
    end
    conclude();
  end
endmodule : mie_core_tb_top
